// ==== astx_line_rx.sv ====
// Far-end receiver model that samples the serial line bit by bit
`timescale 1ns/1ps
module astx_line_rx (
	input  wire logic  clk_sys,
	input  wire logic  lineIn,
	input  wire logic  invert,
	input  wire logic  nineBits,
	input  wire logic  listen,
	input  wire logic [31:0] bitLen,
	input  wire logic [31:0] cyc,
	output logic [8:0] rxData,
	output logic       rxAddr,
	output int         rxCount,
	output int         rxBad,
	output int         rxStart,
	output int         rxGap
);
	logic lvl;
	logic first;
	// Built aside so the last character stays readable during the next one
	logic [8:0] acc;
	int   nBits;

	assign lvl = lineIn ^ invert;

	// Samples 1 ns after each edge, so the line has settled
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	initial begin
		rxCount = 0;
		rxBad = 0;
		rxStart = 0;
		rxGap = 0;
		rxData = '0;
		rxAddr = 1'b0;
		forever begin
			tick();
			if (listen && lvl === 1'b0) begin
				rxGap = cyc - rxStart;
				rxStart = cyc;
				acc = '0;
				nBits = nineBits ? 9 : 8;
				for (int k = 0; k < nBits + 2; k++) begin
					first = lvl;
					repeat (bitLen - 1) tick();
					if (first !== lvl) rxBad++;
					if (k == 0 && first !== 1'b0) rxBad++;
					if (k > 0 && k <= nBits) acc[k - 1] = first;
					if (k == nBits + 1 && first !== 1'b1) rxBad++;
					if (k < nBits + 1) tick();
				end
				rxData = acc;
				rxAddr = nineBits & acc[8];
				rxCount++;
			end
		end
	end
endmodule : astx_line_rx

// ==== astx_pkg.sv ====
// Shared constants, register map and types of the asynchronous serial transmitter
package astx_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADDR_WIDTH = 8;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_STATUS = 8'h04;
	localparam logic [7:0]  OFF_BAUD   = 8'h08;
	localparam logic [7:0]  OFF_DATA   = 8'h0c;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int CTRL_WIDTH   = 11;
	localparam int CTRL_TX_ON   = 0;
	localparam int CTRL_CLOCKED = 1;
	localparam int CTRL_PORT_ON = 2;
	localparam int CTRL_NINE    = 3;
	localparam int CTRL_NINTH   = 4;
	localparam int CTRL_POL_INV = 5;
	localparam int CTRL_BAUD_HS = 6;
	localparam int CTRL_BAUD_WD = 7;
	localparam int CTRL_IRQ_MSK = 8;
	localparam int CTRL_PER_IRQ = 9;
	localparam int CTRL_GLB_IRQ = 10;

	// ------------------------------------------------------------
	// Status field positions
	// ------------------------------------------------------------
	localparam int STAT_BUF_EMPTY   = 0;
	localparam int STAT_SHIFT_EMPTY = 1;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [10:0] CTRL_RESET = 11'h000;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	localparam logic [6:0]  PRE_SLOW   = 7'h40;
	localparam logic [6:0]  PRE_MID    = 7'h10;
	localparam logic [6:0]  PRE_FAST   = 7'h04;
	localparam logic [3:0]  LAST_BIT_8 = 4'h7;
	localparam logic [3:0]  LAST_BIT_9 = 4'h8;

	// ------------------------------------------------------------
	// Bus responses and states
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_START = 4'h2,
		TX_DATA  = 4'h4,
		TX_STOP  = 4'h8
	} astx_state_type;

	// Clocks of the bit-rate prescaler per baud clock
	function automatic logic [6:0] astx_prescale(input logic wide, input logic high);
		if (wide && high) begin
			return PRE_FAST;
		end else if (wide || high) begin
			return PRE_MID;
		end
		return PRE_SLOW;
	endfunction : astx_prescale

endpackage : astx_pkg

// ==== astx_top.sv ====
// Asynchronous serial transmitter with AXI4-Lite register slave
//
// Functional notes
// RQ1 - Frame: low start, 8/9 data, high stop
// RQ2 - Idle line rests at mark level
// RQ3 - Data bits sent least significant first
// RQ4 - Every bit lasts exactly one bit period
// RQ5 - Baud generator divides clock, 8/16-bit counter
// RQ6 - Format and rate shared with receiver
// RQ7 - No hardware parity; ninth bit carries it
// RQ8 - Active only when on, asynchronous, port on
// RQ9 - Idle shifter loads holding register at once
// RQ10 - Pending character loads right after stop bit
// RQ11 - Start bit follows load immediately
// RQ12 - Polarity bit inverts idle and data levels
// RQ13 - Empty flag read-only, set when holding empty; here held clear while the transmitter is not active
// RQ14 - Empty flag valid by second cycle after write
// RQ15 - Interrupt needs mask, peripheral and global enables
// RQ16 - Shift empty status clears during character
// RQ17 - Nine-bit mode sends ninth bit last
// RQ18 - Software writes ninth bit before data
// RQ19 - Ninth bit one marks address character
// RQ20 - Pin turns output automatically when enabled
// RQ21 - Pin released while transmitter disabled
// RQ22 - Disabled: shifter idle, mark, shift empty
`timescale 1ns/1ps
module astx_top (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             serialOut,
	output logic             serialOutEn,
	output logic             txIrq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [10:0]              ctrl;
	logic [15:0]              baudDiv;
	logic [7:0]               wrAddr;
	logic [31:0]              wrData;
	logic [3:0]               wrStrb;
	logic                     awHave;
	logic                     wHave;
	logic                     doWrite;
	logic                     dataWrite;
	logic                     txActive;
	logic                     holdFull;
	logic [8:0]               holdData;
	logic [8:0]               shiftReg;
	logic [3:0]               bitCnt;
	logic                     charNine;
	logic [15:0]              brgCnt;
	logic [6:0]               preCnt;
	logic [15:0]              divEff;
	logic [6:0]               preLoad;
	logic                     bitTick;
	logic                     load;
	logic                     bufEmpty;
	logic                     shiftEmpty;
	logic                     next_line;
	astx_pkg::astx_state_type txState;
	astx_pkg::astx_state_type next_txState;

	assign txActive  = ctrl[astx_pkg::CTRL_TX_ON] && !ctrl[astx_pkg::CTRL_CLOCKED]
		&& ctrl[astx_pkg::CTRL_PORT_ON]; // see RQ8
	assign doWrite   = awHave && wHave && !bvalid;
	assign dataWrite = doWrite && (wrAddr == astx_pkg::OFF_DATA) && wrStrb[0];

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			awHave  <= 1'b0;
			wHave   <= 1'b0;
			wrAddr  <= 8'h00;
			wrData  <= 32'h0000_0000;
			wrStrb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= astx_pkg::RESP_OKAY;
		end else begin
			awready <= !awHave && !(awvalid && awready) && !bvalid;
			wready  <= !wHave && !(wvalid && wready) && !bvalid;
			if (awvalid && awready) begin
				awHave <= 1'b1;
				wrAddr <= awaddr;
			end
			if (wvalid && wready) begin
				wHave  <= 1'b1;
				wrData <= wdata;
				wrStrb <= wstrb;
			end
			if (doWrite) begin
				awHave <= 1'b0;
				wHave  <= 1'b0;
				bvalid <= 1'b1;
				if (wrAddr == astx_pkg::OFF_CTRL || wrAddr == astx_pkg::OFF_BAUD
					|| wrAddr == astx_pkg::OFF_DATA || wrAddr == astx_pkg::OFF_STATUS) begin
					bresp <= astx_pkg::RESP_OKAY;
				end else begin
					bresp <= astx_pkg::RESP_SLVERR;
				end
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl    <= astx_pkg::CTRL_RESET;
			baudDiv <= astx_pkg::BAUD_RESET;
		end else if (doWrite) begin
			if (wrAddr == astx_pkg::OFF_CTRL) begin
				if (wrStrb[0]) begin
					ctrl[7:0] <= wrData[7:0];
				end
				if (wrStrb[1]) begin
					ctrl[10:8] <= wrData[10:8];
				end
			end else if (wrAddr == astx_pkg::OFF_BAUD) begin
				if (wrStrb[0]) begin
					baudDiv[7:0] <= wrData[7:0];
				end
				if (wrStrb[1]) begin
					baudDiv[15:8] <= wrData[15:8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= astx_pkg::RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp  <= astx_pkg::RESP_OKAY;
				rdata  <= 32'h0000_0000;
				if (araddr == astx_pkg::OFF_CTRL) begin
					rdata[10:0] <= ctrl;
				end else if (araddr == astx_pkg::OFF_STATUS) begin
					// Both flags are status only; writes leave them alone
					rdata[astx_pkg::STAT_BUF_EMPTY]   <= bufEmpty;   // see RQ13
					rdata[astx_pkg::STAT_SHIFT_EMPTY] <= shiftEmpty; // see RQ16
				end else if (araddr == astx_pkg::OFF_BAUD) begin
					rdata[15:0] <= baudDiv;
				end else if (araddr != astx_pkg::OFF_DATA) begin
					rresp <= astx_pkg::RESP_SLVERR;
				end
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Baud rate generator
	// ------------------------------------------------------------
	assign divEff  = ctrl[astx_pkg::CTRL_BAUD_WD] ? baudDiv : {8'h00, baudDiv[7:0]}; // see RQ5, RQ6
	assign preLoad = astx_pkg::astx_prescale(ctrl[astx_pkg::CTRL_BAUD_WD], ctrl[astx_pkg::CTRL_BAUD_HS]) - 7'h01;
	assign bitTick = (txState != astx_pkg::TX_IDLE) && (brgCnt == 16'h0000) && (preCnt == 7'h00);

	// Restarted on each load so the start bit is a full period long
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			brgCnt <= 16'h0000;
			preCnt <= 7'h00;
		end else if (load || txState == astx_pkg::TX_IDLE) begin
			brgCnt <= divEff; // see RQ4
			preCnt <= preLoad;
		end else if (brgCnt == 16'h0000) begin
			brgCnt <= divEff;
			preCnt <= (preCnt == 7'h00) ? preLoad : preCnt - 7'h01;
		end else begin
			brgCnt <= brgCnt - 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Holding register
	// ------------------------------------------------------------
	// see RQ9, RQ10
	assign load = txActive && holdFull && (txState == astx_pkg::TX_IDLE
		|| (txState == astx_pkg::TX_STOP && bitTick));

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			holdFull <= 1'b0;
			holdData <= 9'h000;
		end else if (!txActive) begin
			holdFull <= 1'b0;
		end else if (dataWrite) begin
			holdFull <= 1'b1;
			// Ninth bit sampled now, so it must be written first
			holdData <= {ctrl[astx_pkg::CTRL_NINTH], wrData[7:0]}; // see RQ18, RQ19
		end else if (load) begin
			holdFull <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Transmit state machine
	// ------------------------------------------------------------
	always_comb begin
		next_txState = txState;
		case (txState)
			astx_pkg::TX_IDLE: begin
				if (load) begin
					next_txState = astx_pkg::TX_START; // see RQ11
				end
			end
			astx_pkg::TX_START: begin
				if (bitTick) begin
					next_txState = astx_pkg::TX_DATA;
				end
			end
			astx_pkg::TX_DATA: begin
				if (bitTick && bitCnt == (charNine ? astx_pkg::LAST_BIT_9 : astx_pkg::LAST_BIT_8)) begin
					next_txState = astx_pkg::TX_STOP; // see RQ17
				end
			end
			astx_pkg::TX_STOP: begin
				if (load) begin
					next_txState = astx_pkg::TX_START; // see RQ10
				end else if (bitTick) begin
					next_txState = astx_pkg::TX_IDLE;
				end
			end
			default: begin
				next_txState = astx_pkg::TX_IDLE;
			end
		endcase
		if (!txActive) begin
			next_txState = astx_pkg::TX_IDLE; // see RQ22
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			txState <= astx_pkg::TX_IDLE;
		end else begin
			txState <= next_txState;
		end
	end

	// No parity stage exists; nine-bit mode is the only extra bit
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			shiftReg <= 9'h000;
			bitCnt   <= 4'h0;
			charNine <= 1'b0;
		end else if (load) begin
			shiftReg <= holdData; // see RQ7
			bitCnt   <= 4'h0;
			charNine <= ctrl[astx_pkg::CTRL_NINE];
		end else if (txState == astx_pkg::TX_DATA && bitTick) begin
			shiftReg <= {1'b0, shiftReg[8:1]}; // see RQ3
			bitCnt   <= bitCnt + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Line driver and status
	// ------------------------------------------------------------
	always_comb begin
		case (txState)
			astx_pkg::TX_START: next_line = 1'b0;        // see RQ1
			astx_pkg::TX_DATA:  next_line = shiftReg[0];
			default:            next_line = 1'b1;        // see RQ2
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			serialOut   <= 1'b1;
			serialOutEn <= 1'b0;
		end else begin
			serialOut   <= next_line ^ ctrl[astx_pkg::CTRL_POL_INV]; // see RQ12
			serialOutEn <= txActive; // see RQ20, RQ21
		end
	end

	// Flag lags the holding register by one cycle, inside the stale window
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			bufEmpty   <= 1'b0;
			shiftEmpty <= 1'b1;
			txIrq      <= 1'b0;
		end else begin
			bufEmpty   <= txActive && !holdFull; // see RQ13, RQ14
			shiftEmpty <= (next_txState == astx_pkg::TX_IDLE); // see RQ16
			txIrq      <= bufEmpty && ctrl[astx_pkg::CTRL_IRQ_MSK]
				&& ctrl[astx_pkg::CTRL_PER_IRQ] && ctrl[astx_pkg::CTRL_GLB_IRQ]; // see RQ15
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [23:0] periodCnt;
	logic [23:0] expPeriod;

	assign expPeriod = ({8'h00, divEff} + 24'h00_0001) * {17'h0_0000, preLoad + 7'h01};

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			periodCnt <= 24'h00_0000;
		end else if (load || bitTick) begin
			periodCnt <= 24'h00_0000;
		end else begin
			periodCnt <= periodCnt + 24'h00_0001;
		end
	end

	AST_START_LOW: assert property (@(posedge clk_sys) disable iff (reset) // see RQ11
		load |=> ##1 serialOut == $past(ctrl[astx_pkg::CTRL_POL_INV]))
		else $error("start bit not driven after load");

	AST_IDLE_MARK: assert property (@(posedge clk_sys) disable iff (reset) // see RQ2
		(txState == astx_pkg::TX_IDLE) ##1 (txState == astx_pkg::TX_IDLE)
		|-> serialOut == !$past(ctrl[astx_pkg::CTRL_POL_INV]))
		else $error("idle line not at mark");

	AST_STOP_HIGH: assert property (@(posedge clk_sys) disable iff (reset) // see RQ1
		$rose(txState == astx_pkg::TX_STOP) |=> serialOut == !$past(ctrl[astx_pkg::CTRL_POL_INV]))
		else $error("stop bit not at mark");

	AST_LSB_FIRST: assert property (@(posedge clk_sys) disable iff (reset) // see RQ3
		$rose(txState == astx_pkg::TX_DATA)
		|=> serialOut == ($past(shiftReg[0]) ^ $past(ctrl[astx_pkg::CTRL_POL_INV])))
		else $error("first data bit is not the LSB");

	AST_PERIOD: assert property (@(posedge clk_sys) disable iff (reset) // see RQ4
		bitTick && $stable(ctrl) && $stable(baudDiv) |-> periodCnt == expPeriod - 24'h00_0001)
		else $error("bit period length wrong");

	AST_EMPTY_FLAG: assert property (@(posedge clk_sys) disable iff (reset) // see RQ13
		$rose(txActive) && !holdFull |=> bufEmpty)
		else $error("empty flag not set on enable");

	AST_SHIFT_EMPTY: assert property (@(posedge clk_sys) disable iff (reset) // see RQ16
		load |=> !shiftEmpty ##1 (!shiftEmpty || !txActive))
		else $error("shift empty status not cleared by load");

	AST_IRQ: assert property (@(posedge clk_sys) disable iff (reset) // see RQ15
		txIrq |-> $past(bufEmpty && ctrl[astx_pkg::CTRL_IRQ_MSK]
			&& ctrl[astx_pkg::CTRL_PER_IRQ] && ctrl[astx_pkg::CTRL_GLB_IRQ]))
		else $error("interrupt raised without all enables");

	AST_DISABLED: assert property (@(posedge clk_sys) disable iff (reset) // see RQ22
		!txActive |=> !serialOutEn && txState == astx_pkg::TX_IDLE && shiftEmpty)
		else $error("disabled transmitter not idle");

	AST_HOLD_WAIT: assert property (@(posedge clk_sys) disable iff (reset) // see RQ10
		txActive && holdFull && txState == astx_pkg::TX_STOP && bitTick
		|=> txState == astx_pkg::TX_START)
		else $error("pending character not loaded after stop");

endmodule : astx_top

// ==== tb_top.sv ====
// Self-checking bench: register bus tasks and serial transfer tests
`timescale 1ns/1ps
module tb_top;
	logic        clk_sys, reset;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        serialOut, serialOutEn, txIrq, pinLine;
	logic        inv, nine, listen;
	logic [8:0]  rxData;
	logic        rxAddr;
	int          bitLen, rxCount, rxBad, rxStart, rxGap, base, tw;
	int          cyc = 0;
	int          miscompares = 0;
	int          n_checks = 0;

	localparam logic [1:0]  OK  = astx_pkg::RESP_OKAY;
	localparam logic [1:0]  ERR = astx_pkg::RESP_SLVERR;
	localparam logic [31:0] ON  = 32'h1 << astx_pkg::CTRL_TX_ON;
	localparam logic [31:0] PO  = 32'h1 << astx_pkg::CTRL_PORT_ON;
	localparam logic [31:0] EN  = ON | PO;
	localparam logic [31:0] HS  = 32'h1 << astx_pkg::CTRL_BAUD_HS;
	localparam logic [31:0] WD  = 32'h1 << astx_pkg::CTRL_BAUD_WD;
	localparam logic [31:0] N9  = (32'h1 << astx_pkg::CTRL_NINE) | (32'h1 << astx_pkg::CTRL_POL_INV);
	localparam logic [31:0] D9  = 32'h1 << astx_pkg::CTRL_NINTH;
	localparam logic [31:0] SE  = 32'h1 << astx_pkg::STAT_SHIFT_EMPTY;
	localparam logic [31:0] BE  = 32'h1 << astx_pkg::STAT_BUF_EMPTY;
	localparam logic [31:0] MODE [4] = '{HS | WD, WD, HS, 32'h0};
	localparam logic [31:0] DIV [4]  = '{32'h0, 32'h2, 32'h101, 32'h0};
	localparam int          PER [4]  = '{4, 48, 32, 64};
	localparam logic [7:0]  CH [4]   = '{8'ha5, 8'h01, 8'h80, 8'h3c};
	localparam logic [31:0] OFFM [3] = '{EN | (32'h1 << astx_pkg::CTRL_CLOCKED), ON, PO};

	// Released pin is pulled up to the mark level
	assign pinLine = serialOutEn ? serialOut : 1'b1;

	astx_top astx_top_i (.clk_sys(clk_sys), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.serialOut(serialOut), .serialOutEn(serialOutEn), .txIrq(txIrq));

	astx_line_rx astx_line_rx_i (.clk_sys(clk_sys), .lineIn(pinLine), .invert(inv), .nineBits(nine),
		.listen(listen), .bitLen(bitLen), .cyc(cyc), .rxData(rxData), .rxAddr(rxAddr),
		.rxCount(rxCount), .rxBad(rxBad), .rxStart(rxStart), .rxGap(rxGap));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) cyc <= cyc + 1;

	// ------------------------------------------------------------
	// Bus and checking tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic guard(inout int n);
		n++;
		if (n > 20000) begin
			miscompares++;
			$display("mismatch wait expected %h seen %h", 0, n);
			report_and_stop();
		end
	endtask : guard

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int         n;
		logic       hA, hW, hB;
		logic [1:0] r;
		n = 0;
		hB = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		#1;
		while (!hB) begin
			hA = awvalid && awready;
			hW = wvalid && wready;
			hB = bvalid && bready;
			r = bresp;
			@(posedge clk_sys);
			if (hA) awvalid <= 1'b0;
			if (hW) wvalid <= 1'b0;
			if (hB) bready <= 1'b0;
			#1;
			guard(n);
		end
		check("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr

	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int          n;
		logic        hA, hR;
		logic [31:0] d;
		logic [1:0]  r;
		n = 0;
		hR = 1'b0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		#1;
		while (!hR) begin
			hA = arvalid && arready;
			hR = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (hA) arvalid <= 1'b0;
			if (hR) rready <= 1'b0;
			#1;
			guard(n);
		end
		check(what, exp, d);
		check("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd

	task automatic wait_rx(input int cnt);
		int n;
		n = 0;
		while (rxCount < cnt) begin
			tick();
			guard(n);
		end
	endtask : wait_rx

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		{inv, nine} = 2'b00;
		listen = 1'b1;
		bitLen = 4;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		check("line", 32'h1, 32'(serialOut));
		check("pinEn", 32'h0, 32'(serialOutEn));
		check("irq", 32'h0, 32'(txIrq));
		rd("ctrl", astx_pkg::OFF_CTRL, 32'h0, OK);
		rd("baud", astx_pkg::OFF_BAUD, 32'h0, OK);
		wr(astx_pkg::OFF_STATUS, 32'h3, OK);
		wr(8'h10, 32'h1, ERR);
		rd("status", astx_pkg::OFF_STATUS, SE, OK);
		rd("unmapped", 8'h10, 32'h0, ERR);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			bitLen = PER[i];
			wr(astx_pkg::OFF_BAUD, DIV[i], OK);
			wr(astx_pkg::OFF_CTRL, EN | MODE[i], OK);
			rd("status", astx_pkg::OFF_STATUS, BE | SE, OK);
			check("pinEn", 32'h1, 32'(serialOutEn));
			check("idle", 32'h1, 32'(serialOut));
			base = rxCount;
			wr(astx_pkg::OFF_DATA, {24'h0, CH[i]}, OK);
			tw = cyc;
			wr(astx_pkg::OFF_DATA, {24'h0, ~CH[i]}, OK);
			rd("status", astx_pkg::OFF_STATUS, 32'h0, OK);
			check("start", 32'h1, 32'(rxStart >= tw - 2 && rxStart <= tw + 2));
			wait_rx(base + 1);
			check("char", {24'h0, CH[i]}, {23'h0, rxData});
			wait_rx(base + 2);
			check("char", {24'h0, ~CH[i]}, {23'h0, rxData});
			check("gap", 32'(10 * PER[i]), 32'(rxGap));
			rd("status", astx_pkg::OFF_STATUS, BE | SE, OK);
			$display("test rate %0d done", i);
		end
		listen = 1'b0;
		bitLen = 4;
		wr(astx_pkg::OFF_BAUD, 32'h0, OK);
		wr(astx_pkg::OFF_CTRL, EN | HS | WD | N9 | D9, OK);
		check("idle", 32'h0, 32'(serialOut));
		{inv, nine, listen} = 3'b111;
		base = rxCount;
		wr(astx_pkg::OFF_DATA, 32'h5a, OK);
		wait_rx(base + 1);
		check("char", 32'h15a, {23'h0, rxData});
		check("addr", 32'h1, 32'(rxAddr));
		wr(astx_pkg::OFF_CTRL, EN | HS | WD | N9, OK);
		wr(astx_pkg::OFF_DATA, 32'h81, OK);
		wait_rx(base + 2);
		check("char", 32'h081, {23'h0, rxData});
		check("addr", 32'h0, 32'(rxAddr));
		$display("test nine bit done");
		listen = 1'b0;
		for (int m = 0; m < 8; m++) begin
			wr(astx_pkg::OFF_CTRL, EN | (32'(m) << astx_pkg::CTRL_IRQ_MSK), OK);
			tick();
			check("irq", 32'(m == 7), 32'(txIrq));
			rd("status", astx_pkg::OFF_STATUS, BE | SE, OK);
		end
		{inv, nine} = 2'b00;
		$display("test irq done");
		bitLen = 64;
		for (int j = 0; j < 3; j++) begin
			wr(astx_pkg::OFF_CTRL, EN, OK);
			wr(astx_pkg::OFF_DATA, 32'h0, OK);
			wr(astx_pkg::OFF_CTRL, OFFM[j], OK);
			tick();
			check("pinEn", 32'h0, 32'(serialOutEn));
			check("line", 32'h1, 32'(serialOut));
			rd("status", astx_pkg::OFF_STATUS, SE, OK);
			wr(astx_pkg::OFF_DATA, 32'hff, OK);
		end
		listen = 1'b1;
		base = rxCount;
		wr(astx_pkg::OFF_CTRL, EN, OK);
		wr(astx_pkg::OFF_DATA, 32'hc3, OK);
		wait_rx(base + 1);
		check("char", 32'hc3, {23'h0, rxData});
		check("frame", 32'h0, 32'(rxBad));
		$display("test disable done");
		report_and_stop();
	end
endmodule : tb_top
